// ===== logic/acb_pkg.sv
// acb_pkg: constants and carrier types for the array counter byte access block
// assumes an 8-bit register port with single-cycle read and write strobes
package acb_pkg;
    localparam int          ACB_DATA_W   = 8;
    localparam int          ACB_CNT_W    = 16;
    localparam logic [7:0]  ACB_ADDR_LOW = 8'hF9;
    localparam logic [7:0]  ACB_ADDR_HIGH = 8'hFA;
    localparam logic [7:0]  ACB_BYTE_RST = 8'h00;
    localparam logic [15:0] ACB_CNT_RST  = 16'h0000;
    localparam logic [15:0] ACB_CNT_STEP = 16'h0001;
    localparam int          ACB_LOW_LSB  = 0;
    localparam int          ACB_LOW_MSB  = 7;
    localparam int          ACB_HIGH_LSB = 8;
    localparam int          ACB_HIGH_MSB = 15;

    // one register-port request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acb_req_t;

    // answer to a read
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } acb_rsp_t;
endpackage

// ===== logic/acb_counter.sv
// acb_counter: 16-bit array counter with byte-wide software access
// assumes the count event and watchdog enable come from logic on the same clock
//
// Function
// - low counter byte readable and writable at its register address
// - high counter byte exposed at its register address
// - high byte reads a snapshot refreshed only when the low byte is read
// - low byte writes ignored while watchdog enable is set
// - high byte writes ignored while watchdog enable is set
//
// behaviour notes for whoever wires this in:
// the high byte is never read live; it always comes from the snapshot, so
// software must read the low byte first to get a coherent sixteen-bit value
// reading the high byte twice returns the same snapshot both times, even if
// the counter has moved on in between; this is intended, not a fault
// a write and a count event in one cycle: the written byte wins, the other
// byte keeps the incremented value, so a carry can still reach the high byte
// while the low byte is being written; software that wants an exact load
// should stop the count source around the two writes
// the watchdog bit blocks writes silently; no error is reported, the write
// simply has no effect, which matches how the register port treats any
// other refused access
// reads of any address other than the two counter bytes answer zero with
// valid set, so the port never stalls on a stray address
// read answers stand for exactly one cycle after the taking edge
`timescale 1ns/100ps
`default_nettype none
module acb_counter (
    input  wire logic            clk,                 // 125 MHz system clock
    input  wire logic            rst_b,               // asynchronous reset, active low
    input  wire acb_pkg::acb_req_t req,               // register port request
    input  wire logic            count_event,         // selected count event, one cycle
    input  wire logic            watchdog_enable_bit, // write block while high
    output var acb_pkg::acb_rsp_t rsp,                // registered read answer
    output logic [15:0]          array_count_value    // live counter value
);
    import acb_pkg::*;

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [7:0]  snap_reg;
    logic [7:0]  snap_next;
    acb_rsp_t    rsp_reg;
    acb_rsp_t    rsp_next;
    logic        wr_low;
    logic        wr_high;
    logic        rd_low;
    logic        rd_high;

    // address match shared by reads, writes and checks so all see one map
    function automatic logic acb_hit(input acb_req_t r, input logic [7:0] a);
        return (r.addr == a);
    endfunction

    // decode; the watchdog bit gates writes so a running watchdog cannot be fooled
    assign rd_low  = req.rd && acb_hit(req, ACB_ADDR_LOW);
    assign rd_high = req.rd && acb_hit(req, ACB_ADDR_HIGH);
    assign wr_low  = req.wr && acb_hit(req, ACB_ADDR_LOW) && !watchdog_enable_bit;
    assign wr_high = req.wr && acb_hit(req, ACB_ADDR_HIGH) && !watchdog_enable_bit;

    // next counter, snapshot and answer; a write takes priority over the count event
    always_comb begin
        cnt_next  = cnt_reg;
        snap_next = snap_reg;
        rsp_next  = '{valid: 1'b0, data: ACB_BYTE_RST};
        if (count_event) begin
            cnt_next = cnt_reg + ACB_CNT_STEP;
        end
        if (wr_low) begin
            cnt_next[ACB_LOW_MSB:ACB_LOW_LSB] = req.wdata;
        end
        if (wr_high) begin
            cnt_next[ACB_HIGH_MSB:ACB_HIGH_LSB] = req.wdata;
        end
        if (rd_low) begin
            snap_next = cnt_reg[ACB_HIGH_MSB:ACB_HIGH_LSB];
            rsp_next  = '{valid: 1'b1, data: cnt_reg[ACB_LOW_MSB:ACB_LOW_LSB]};
        end else if (rd_high) begin
            rsp_next = '{valid: 1'b1, data: snap_reg};
        end else if (req.rd) begin
            rsp_next = '{valid: 1'b1, data: ACB_BYTE_RST}; // unmapped reads as zero
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg  <= ACB_CNT_RST;
            snap_reg <= ACB_BYTE_RST;
            rsp_reg  <= '0;
        end else begin
            cnt_reg  <= cnt_next;
            snap_reg <= snap_next;
            rsp_reg  <= rsp_next;
        end
    end

    assign rsp               = rsp_reg;
    assign array_count_value = cnt_reg;

    // a blocked low byte write leaves the whole counter alone
    AST_WR_LOW_BLOCKED: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && acb_hit(req, ACB_ADDR_LOW) && watchdog_enable_bit && !count_event)
        |=> cnt_reg == $past(cnt_reg))
        else $error("low byte changed while watchdog enabled");

    // a blocked high byte write leaves the whole counter alone
    AST_WR_HIGH_BLOCKED: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && acb_hit(req, ACB_ADDR_HIGH) && watchdog_enable_bit && !count_event)
        |=> cnt_reg == $past(cnt_reg))
        else $error("high byte changed while watchdog enabled");

    // any write at all while the watchdog runs is refused
    AST_WDOG_BLOCKS_ALL: assert property (@(posedge clk) disable iff (!rst_b)
        (watchdog_enable_bit && !count_event) |=> $stable(cnt_reg))
        else $error("counter changed while watchdog enabled");

    // an accepted low byte write lands in the next cycle
    AST_WR_LOW_TAKES: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && acb_hit(req, ACB_ADDR_LOW) && !watchdog_enable_bit)
        |=> cnt_reg[ACB_LOW_MSB:ACB_LOW_LSB] == $past(req.wdata))
        else $error("low byte write lost");

    // an accepted high byte write lands in the next cycle
    AST_WR_HIGH_TAKES: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && acb_hit(req, ACB_ADDR_HIGH) && !watchdog_enable_bit)
        |=> cnt_reg[ACB_HIGH_MSB:ACB_HIGH_LSB] == $past(req.wdata))
        else $error("high byte write lost");

    // a low byte write on a quiet counter must not disturb the high byte
    AST_WR_LOW_KEEPS_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_low && !wr_high && !count_event)
        |=> cnt_reg[ACB_HIGH_MSB:ACB_HIGH_LSB] == $past(cnt_reg[ACB_HIGH_MSB:ACB_HIGH_LSB]))
        else $error("low byte write disturbed high byte");

    // a high byte write on a quiet counter must not disturb the low byte
    AST_WR_HIGH_KEEPS_LOW: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_high && !wr_low && !count_event)
        |=> cnt_reg[ACB_LOW_MSB:ACB_LOW_LSB] == $past(cnt_reg[ACB_LOW_MSB:ACB_LOW_LSB]))
        else $error("high byte write disturbed low byte");

    // low byte read answers with the live low byte
    AST_RD_LOW_DATA: assert property (@(posedge clk) disable iff (!rst_b)
        (req.rd && acb_hit(req, ACB_ADDR_LOW))
        |=> rsp.valid && rsp.data == $past(cnt_reg[ACB_LOW_MSB:ACB_LOW_LSB]))
        else $error("low byte read data wrong");

    // high byte read answers from the snapshot, never the live count
    AST_RD_HIGH_DATA: assert property (@(posedge clk) disable iff (!rst_b)
        (req.rd && acb_hit(req, ACB_ADDR_HIGH))
        |=> rsp.valid && rsp.data == $past(snap_reg))
        else $error("high byte read not from snapshot");

    // the snapshot takes the high byte at the low byte read
    AST_SNAP_LOAD_DIRECT: assert property (@(posedge clk) disable iff (!rst_b)
        (req.rd && acb_hit(req, ACB_ADDR_LOW))
        |=> snap_reg == $past(cnt_reg[ACB_HIGH_MSB:ACB_HIGH_LSB]))
        else $error("snapshot load wrong");

    // low then high read gives the high byte as it was at the low read
    AST_SNAP_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        (req.rd && acb_hit(req, ACB_ADDR_LOW)) ##1 (req.rd && acb_hit(req, ACB_ADDR_HIGH))
        |=> rsp.data == $past(cnt_reg[ACB_HIGH_MSB:ACB_HIGH_LSB], 2))
        else $error("snapshot not taken on low byte read");

    // nothing but a low byte read may move the snapshot
    AST_SNAP_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !(req.rd && acb_hit(req, ACB_ADDR_LOW)) |=> $stable(snap_reg))
        else $error("snapshot changed without low byte read");

    // with no read the answer is idle and zero
    AST_RSP_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
        !req.rd |=> !rsp.valid && rsp.data == ACB_BYTE_RST)
        else $error("answer without a read");

    // a stray address still answers, with zero
    AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_b)
        (req.rd && !acb_hit(req, ACB_ADDR_LOW) && !acb_hit(req, ACB_ADDR_HIGH))
        |=> rsp.valid && rsp.data == ACB_BYTE_RST)
        else $error("unmapped read not zero");

    // one count event, no accepted write: exactly one step
    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_b)
        (count_event && !wr_low && !wr_high)
        |=> cnt_reg == ACB_CNT_W'($past(cnt_reg) + ACB_CNT_STEP))
        else $error("counter did not step by one");

    // all ones wraps to zero instead of sticking
    AST_COUNT_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
        (count_event && !wr_low && !wr_high && cnt_reg == '1)
        |=> cnt_reg == ACB_CNT_RST)
        else $error("counter did not wrap to zero");

    // no event and no accepted write: the counter stands
    AST_COUNT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (!count_event && !wr_low && !wr_high) |=> $stable(cnt_reg))
        else $error("counter moved without a cause");

    // during reset both bytes and the snapshot sit at zero
    AST_RESET_VALUES: assert property (@(posedge clk)
        !rst_b |-> cnt_reg == ACB_CNT_RST && snap_reg == ACB_BYTE_RST && !rsp.valid)
        else $error("reset values wrong");
endmodule
`default_nettype wire

// ===== testbench/tb_array_counter_byte_access.sv
// tb_array_counter_byte_access: register-level checks of acb_counter
// assumes inputs move on the falling edge and read answers stand one cycle
`timescale 1ns/100ps
`default_nettype none
module tb_array_counter_byte_access;
    import acb_pkg::*;
    logic        clk, rst_b, count_event, watchdog_enable_bit;
    acb_req_t    req;
    acb_rsp_t    rsp;
    logic [15:0] array_count_value;
    int          err_count, checked;
    acb_counter u_acb_counter (.clk(clk), .rst_b(rst_b), .req(req), .count_event(count_event),
        .watchdog_enable_bit(watchdog_enable_bit), .rsp(rsp),
        .array_count_value(array_count_value));
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // answer is sampled at the falling edge after the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk) req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge clk) req = '0;
        cmp({7'h00, rsp.valid, rsp.data}, {8'h01, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) req = '{1'b0, 1'b1, a, d};
        @(negedge clk) req = '0;
    endtask
    // held high for n cycles gives n increments
    task automatic pulse(input int n);
        @(negedge clk) count_event = 1'b1;
        repeat (n) @(negedge clk);
        count_event = 1'b0;
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_b = 1'b0;
        req = '0;
        count_event = 1'b0;
        watchdog_enable_bit = 1'b0;
        err_count = 0;
        checked = 0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        rd(ACB_ADDR_LOW, 8'h00);
        rd(ACB_ADDR_HIGH, 8'h00);
        wr(ACB_ADDR_LOW, 8'h34);
        wr(ACB_ADDR_HIGH, 8'h12);
        cmp(array_count_value, 16'h1234);
        cmp({7'h00, rsp.valid, rsp.data}, 16'h0000);
        rd(ACB_ADDR_HIGH, 8'h00);
        rd(ACB_ADDR_LOW, 8'h34);
        pulse(204);
        cmp(array_count_value, 16'h1300);
        rd(ACB_ADDR_HIGH, 8'h12);
        watchdog_enable_bit = 1'b1;
        wr(ACB_ADDR_LOW, 8'hAB);
        wr(ACB_ADDR_HIGH, 8'hCD);
        cmp(array_count_value, 16'h1300);
        @(negedge clk) watchdog_enable_bit = 1'b0;
        wr(ACB_ADDR_LOW, 8'hFF);
        wr(ACB_ADDR_HIGH, 8'hFF);
        pulse(1);
        cmp(array_count_value, 16'h0000);
        rd(8'hF8, 8'h00);
        test_done();
    end
    // hang guard, runs well past the expected 236 cycles
    initial begin
        #8000;
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
